// >>> design/cpu_addr_defines.vh
// Constants for the operand addressing decoder
`ifndef CPU_ADDR_DEFINES_VH
`define CPU_ADDR_DEFINES_VH
`define ADR_CTRL 8'h00
`define ADR_OPERAND 8'h04
`define ADR_CORE 8'h08
`define ADR_RESULT 8'h0c
`define ADR_STATUS 8'h10
`define CTRL_FORM_LSB 0
`define CTRL_SEL_LSB 4
`define CTRL_ARITH 6
`define CTRL_GO 7
`define CTRL_MOVE 8
`define CTRL_REGSPACE 9
`define FLAGS_BANK_BIT 4
`define FORM_SRC_IMM 3'h0
`define FORM_SRC_DIR 3'h1
`define FORM_SRC_IDX 3'h2
`define FORM_DST_DIR 3'h3
`define FORM_DST_IDX 3'h4
`define FORM_DST_DIR_IMM 3'h5
`define FORM_DST_IDX_IMM 3'h6
`define FORM_MEM_MEM 3'h7
`define SEL_ACC 2'h0
`define SEL_INDEX 2'h1
`define SEL_SP 2'h2
`define SEL_FLAGS 2'h3
`define KIND_REG 2'h0
`define KIND_RAM 2'h1
`define KIND_REGSPACE 2'h2
`define KIND_IMM 2'h3
`define LEN_TWO 2'h2
`define LEN_THREE 2'h3
`define PCL_RESET 8'h00
`define FLAGS_RESET 8'h02
`endif

// >>> design/cpu_operand_addressing.v
// Operand addressing decoder with APB register access
`timescale 1ns/1ps
`include "cpu_addr_defines.vh"
module cpu_operand_addressing (
  input wire sys_clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg [7:0] program_counter_low_byte
);
  reg [2:0] form;
  reg [1:0] sel;
  reg arith;
  reg move_instruction;
  reg regspace;
  reg [7:0] op1;
  reg [7:0] op2;
  reg [7:0] acc;
  reg [7:0] index_reg;
  reg [7:0] stack_pointer_register;
  reg [7:0] flags;
  reg [31:0] result;
  reg illegal;
  reg done;
  reg go;
  reg [7:0] dst_addr;
  reg [7:0] src_addr;
  reg [1:0] dst_kind;
  reg [1:0] src_kind;
  reg [1:0] dst_reg;
  reg [1:0] src_reg;
  reg [1:0] length;
  reg read_dest;
  reg bad;
  reg [31:0] next_prdata;
  reg next_slverr;
  wire [7:0] indexed_addr;
  wire mem_kind_sel;
  wire register_bank_select;
  wire setup;
  wire access_done;
  wire [1:0] mem_kind;
  reg [2:0] next_form;
  reg [1:0] next_sel;
  reg next_arith;
  reg next_move_instruction;
  reg next_regspace;
  reg next_go;
  reg [7:0] next_op1;
  reg [7:0] next_op2;
  reg [7:0] next_acc;
  reg [7:0] next_index_reg;
  reg [7:0] next_stack_pointer_register;
  reg [7:0] next_flags;
  reg next_done;
  reg next_illegal;
  reg [7:0] next_program_counter_low_byte;
  reg [31:0] next_result;
  reg next_pready;
  reg next_pslverr;
  reg [31:0] next_read_data;
  wire write_hit;
  wire status_clear;
  wire [31:0] ctrl_image;
  wire [31:0] operand_image;
  wire [31:0] core_image;
  wire [31:0] status_image;

  index_adder u_index_adder (
    .base(op1),
    .index(index_reg),
    .sum(indexed_addr)
  );

  assign register_bank_select = flags[`FLAGS_BANK_BIT];
  assign mem_kind_sel = regspace;
  assign mem_kind = mem_kind_sel ? `KIND_REGSPACE : `KIND_RAM;
  assign setup = psel & ~penable;
  assign access_done = psel & penable & pready;
  assign write_hit = access_done & pwrite;
  assign status_clear = write_hit & (paddr == `ADR_STATUS);

  // Read images; go always reads back as zero
  assign ctrl_image = {22'h000000, regspace, move_instruction, 1'b0, arith, sel, 1'b0, form};
  assign operand_image = {16'h0000, op2, op1};
  assign core_image = {flags, stack_pointer_register, index_reg, acc};
  assign status_image = {30'h00000000, illegal, done};

  // Decode of one instruction's operand routing, every form spelled out
  always @* begin
    dst_addr = 8'h00;
    src_addr = 8'h00;
    dst_kind = `KIND_REG;
    src_kind = `KIND_IMM;
    dst_reg = sel;
    src_reg = sel;
    length = `LEN_TWO;
    read_dest = 1'b0;
    bad = 1'b0;
    case (form)
      `FORM_SRC_IMM: begin
        dst_kind = `KIND_REG;
        dst_reg = sel;
        src_kind = `KIND_IMM;
        src_reg = sel;
        length = `LEN_TWO;
        read_dest = 1'b0;
        bad = 1'b0;
      end
      `FORM_SRC_DIR: begin
        dst_kind = `KIND_REG;
        dst_reg = sel;
        src_kind = mem_kind;
        src_addr = op1;
        length = `LEN_TWO;
        // Only accumulator or index may take the result
        bad = sel[1];
      end
      `FORM_SRC_IDX: begin
        dst_kind = `KIND_REG;
        dst_reg = sel;
        src_kind = mem_kind;
        src_addr = indexed_addr;
        length = `LEN_TWO;
        bad = sel[1];
      end
      `FORM_DST_DIR: begin
        dst_kind = mem_kind;
        dst_addr = op1;
        src_kind = `KIND_REG;
        src_reg = sel;
        length = `LEN_TWO;
        read_dest = arith;
        bad = sel[1];
      end
      `FORM_DST_IDX: begin
        dst_kind = mem_kind;
        dst_addr = indexed_addr;
        src_kind = `KIND_REG;
        src_reg = `SEL_ACC;
        length = `LEN_TWO;
        read_dest = arith;
        bad = (sel != `SEL_ACC);
      end
      `FORM_DST_DIR_IMM: begin
        dst_kind = mem_kind;
        dst_addr = op1;
        src_kind = `KIND_IMM;
        length = `LEN_THREE;
        read_dest = arith;
        bad = 1'b0;
      end
      `FORM_DST_IDX_IMM: begin
        dst_kind = mem_kind;
        dst_addr = indexed_addr;
        src_kind = `KIND_IMM;
        length = `LEN_THREE;
        read_dest = arith;
        bad = 1'b0;
      end
      `FORM_MEM_MEM: begin
        // RAM on both sides; register space is not reachable here
        dst_kind = `KIND_RAM;
        dst_addr = op1;
        src_kind = `KIND_RAM;
        src_addr = op2;
        length = `LEN_THREE;
        read_dest = 1'b0;
        bad = ~move_instruction | arith;
      end
      default: begin
        bad = 1'b1;
      end
    endcase
  end

  // Register read mux, prepared in setup for a one-cycle access
  always @* begin
    next_prdata = 32'h00000000;
    next_slverr = 1'b0;
    case (paddr)
      `ADR_CTRL: begin
        next_prdata = ctrl_image;
      end
      `ADR_OPERAND: begin
        next_prdata = operand_image;
      end
      `ADR_CORE: begin
        next_prdata = core_image;
      end
      `ADR_RESULT: begin
        next_prdata = result;
      end
      `ADR_STATUS: begin
        next_prdata = status_image;
      end
      default: begin
        next_slverr = 1'b1;
      end
    endcase
  end

  // APB slave: pready follows setup by one cycle, so no wait states
  always @* begin
    next_pready = setup;
    next_pslverr = setup & next_slverr;
    next_read_data = 32'h00000000;
    if (setup & ~pwrite) begin
      next_read_data = next_prdata;
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_read_data;
    end
  end

  // Next values of the software-visible control and core image
  always @* begin
    next_form = form;
    next_sel = sel;
    next_arith = arith;
    next_move_instruction = move_instruction;
    next_regspace = regspace;
    next_go = 1'b0;
    next_op1 = op1;
    next_op2 = op2;
    next_acc = acc;
    next_index_reg = index_reg;
    next_stack_pointer_register = stack_pointer_register;
    next_flags = flags;
    if (write_hit) begin
      case (paddr)
        `ADR_CTRL: begin
          next_form = pwdata[`CTRL_FORM_LSB+2:`CTRL_FORM_LSB];
          next_sel = pwdata[`CTRL_SEL_LSB+1:`CTRL_SEL_LSB];
          next_arith = pwdata[`CTRL_ARITH];
          next_move_instruction = pwdata[`CTRL_MOVE];
          next_regspace = pwdata[`CTRL_REGSPACE];
          // One-cycle strobe, so an old go never replays
          next_go = pwdata[`CTRL_GO];
        end
        `ADR_OPERAND: begin
          next_op1 = pwdata[7:0];
          next_op2 = pwdata[15:8];
        end
        `ADR_CORE: begin
          next_acc = pwdata[7:0];
          next_index_reg = pwdata[15:8];
          next_stack_pointer_register = pwdata[23:16];
          // Supervisor bit is read only
          next_flags = {pwdata[31:28], flags[3], pwdata[26:24]};
        end
        default: begin
          next_go = 1'b0;
        end
      endcase
    end
  end

  // Software-visible control and core image
  always @(posedge sys_clk) begin
    if (rst) begin
      form <= `FORM_SRC_IMM;
      sel <= `SEL_ACC;
      arith <= 1'b0;
      move_instruction <= 1'b0;
      regspace <= 1'b0;
      go <= 1'b0;
      op1 <= 8'h00;
      op2 <= 8'h00;
      acc <= 8'h00;
      index_reg <= 8'h00;
      stack_pointer_register <= 8'h00;
      flags <= `FLAGS_RESET;
    end else begin
      form <= next_form;
      sel <= next_sel;
      arith <= next_arith;
      move_instruction <= next_move_instruction;
      regspace <= next_regspace;
      go <= next_go;
      op1 <= next_op1;
      op2 <= next_op2;
      acc <= next_acc;
      index_reg <= next_index_reg;
      stack_pointer_register <= next_stack_pointer_register;
      flags <= next_flags;
    end
  end

  // Sticky status; a decode sets its flag even if cleared in that cycle
  always @* begin
    next_done = done;
    next_illegal = illegal;
    if (status_clear & pwdata[0]) begin
      next_done = 1'b0;
    end
    if (status_clear & pwdata[1]) begin
      next_illegal = 1'b0;
    end
    if (go) begin
      next_done = 1'b1;
    end
    if (go & bad) begin
      next_illegal = 1'b1;
    end
  end

  // Program counter low byte and latched routing word
  always @* begin
    next_program_counter_low_byte = program_counter_low_byte;
    next_result = result;
    if (go & ~bad) begin
      // Advances only by length; not reachable from the bus
      next_program_counter_low_byte = program_counter_low_byte + {6'h00, length};
      // Only two bits of the second operand fit beside the routing fields
      next_result = {op2[1:0], register_bank_select, read_dest, src_reg, dst_reg,
                     src_kind, dst_kind, length, 2'h0, src_addr, dst_addr};
    end
  end

  // Decode latch and program counter low byte
  always @(posedge sys_clk) begin
    if (rst) begin
      program_counter_low_byte <= `PCL_RESET;
      result <= 32'h00000000;
      illegal <= 1'b0;
      done <= 1'b0;
    end else begin
      program_counter_low_byte <= next_program_counter_low_byte;
      result <= next_result;
      illegal <= next_illegal;
      done <= next_done;
    end
  end
endmodule

// >>> design/index_adder.v
// Eight-bit operand plus index address adder
`timescale 1ns/1ps
module index_adder (
  input wire [7:0] base,
  input wire [7:0] index,
  output wire [7:0] sum
);
  wire [8:0] full_sum;
  assign full_sum = {1'b0, base} + {1'b0, index};
  // Carry dropped on purpose, address wraps
  assign sum = full_sum[7:0];
endmodule

// >>> dv/cpu_addr_chk.sv
// Port-level checks for the operand addressing block
`timescale 1ns/1ps
module cpu_addr_chk (
  input wire sys_clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [7:0] program_counter_low_byte
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire [7:0] pc = program_counter_low_byte;
  wire wr_ctrl = psel && penable && pready && pwrite && paddr == 8'h00;
  a_ready_setup: assert property (psel && !penable |=> pready) else $error("no ready");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
  a_ready_access: assert property (pready |-> psel && penable) else $error("stray ready");
  a_err_unmapped: assert property (pready && (paddr > 8'h10 || paddr[1:0] != 2'h0) |-> pslverr)
    else $error("no error on hole");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("read data idle");
  // Own disable so the check still runs while reset is high
  a_pc_reset: assert property (disable iff (1'b0) rst |=> pc == 8'h00)
    else $error("pc not cleared");
  a_pc_step: assert property (!$past(rst) && $changed(pc) |-> 8'(pc - $past(pc)) inside {8'h02, 8'h03})
    else $error("pc step");
  a_pc_cause: assert property (!$past(rst) && $changed(pc) |-> $past(wr_ctrl, 2) || $past(wr_ctrl, 3))
    else $error("pc moved alone");
  cover property (pslverr);
  cover property ($changed(pc));
  cover property (pready && pwrite);
endmodule
bind cpu_operand_addressing cpu_addr_chk chk_u (.sys_clk, .rst, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .program_counter_low_byte);

// >>> dv/cpu_operand_addressing_tb.sv
// Register-level bench for the operand addressing block
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fails++; $display("FAIL %s exp %h got %h", n, e, g); end end
module cpu_operand_addressing_tb;
  logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, pcl, pc;
  logic [31:0] pwdata, prdata, q;
  int fails, checks, i;
  // Masks keep only the fields each form fixes
  logic [31:0] te [8] = '{32'h20c80000, 32'h20482000, 32'h20481000, 32'h20180020,
    32'h20180010, 32'h20dc0020, 32'h20dc0010, 32'h005c5520};
  logic [31:0] tm [8] = '{32'h20fc0000, 32'h20fcff00, 32'h20fcff00, 32'h20fc00ff,
    32'h20fc00ff, 32'h20fc00ff, 32'h20fc00ff, 32'h00fcffff};
  cpu_operand_addressing dut_u (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .program_counter_low_byte(pcl));
  always #5 sys_clk = ~sys_clk;
  task end_sim;
    begin
      if (fails == 0 && checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    begin
      @(posedge sys_clk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1;
      n = 0;
      do begin
        @(posedge sys_clk);
        n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
        fails++;
        end_sim();
      end
      q = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
    end
  endtask
  task decode(input logic [31:0] c);
    begin
      xfer(1, 8'h00, c);
      repeat (3) @(posedge sys_clk);
      xfer(0, 8'h0c, 0);
    end
  endtask
  initial begin
    sys_clk = 0;
    rst = 1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    fails = 0;
    checks = 0;
    pc = 0;
    repeat (8) @(posedge sys_clk);
    rst <= 0;
    @(posedge sys_clk);
    `CHK("pc", 8'h00, pcl)
    xfer(0, 8'h08, 0);
    `CHK("core", 32'h02000000, q)
    xfer(1, 8'h08, 32'h1000f000);
    xfer(1, 8'h04, 32'h5520);
    for (i = 0; i < 8; i++) begin
      decode(i == 7 ? 32'h187 : 32'h80 | i);
      pc += (i < 5) ? 8'h02 : 8'h03;
      `CHK("result", te[i], q & tm[i])
      `CHK("pc", pc, pcl)
    end
    xfer(1, 8'h10, 32'h3);
    decode(32'h87);
    xfer(0, 8'h10, 0);
    `CHK("status", 32'h3, q)
    decode(32'h94);
    `CHK("pc", pc, pcl)
    xfer(1, 8'h08, 32'h0000f000);
    decode(32'hc3);
    pc += 8'h02;
    `CHK("bank", 2'b01, q[29:28])
    decode(32'ha0);
    `CHK("sp route", 4'ha, q[27:24])
    decode(32'h291);
    `CHK("regspace", 6'h16, q[27:22])
    pc += 8'h04;
    `CHK("pc", pc, pcl)
    xfer(0, 8'h14, 0);
    `CHK("hole", 33'h100000000, {err, q})
    end_sim();
  end
endmodule
